// >>> hdl/ldd_regs.svh
// Command layout, reset values, instruction codes and timing constants of the LED frame block.
`ifndef LDD_REGS_SVH
`define LDD_REGS_SVH

// ==========================================================================
// Command word layout
// ==========================================================================
`define LDD_CMD_RST 16'h02b0
`define LDD_CMD_FMT 15
`define LDD_CMD_PWM 12
`define LDD_CMD_CRST 11
`define LDD_CMD_SYNC 10
`define LDD_CMD_GCC_HI 9
`define LDD_CMD_GCC_LO 4
`define LDD_CMD_VTH_HI 3
`define LDD_CMD_VTH_LO 2
`define LDD_CMD_WDOG 0

// ==========================================================================
// Instruction codes
// ==========================================================================
// Normal mode: shift-clock pulse count with its lowest bit dropped.
`define LDD_N_DATA 3'h0
`define LDD_N_GLOBAL 3'h1
`define LDD_N_READ 3'h3
`define LDD_N_NORMAL 3'h4
`define LDD_N_WCMD 3'h5
`define LDD_N_CRST 3'h6
// Error detection mode: exact serial-input pulse count.
`define LDD_E_OPEN 4'h2
`define LDD_E_SHORT 4'h4
`define LDD_E_S2G 4'h6
`define LDD_E_THERM 4'h8
`define LDD_E_SMART 4'ha
`define LDD_E_SLEEP 4'hc
`define LDD_E_REXT 4'he

// ==========================================================================
// Channel data and timing
// ==========================================================================
`define LDD_LAST_CH 4'hf
`define LDD_ALL_ON 16'hffff
`define LDD_CNT_MAX 16'hffff
`define LDD_WDOG_MS 30
`define LDD_CLK_KHZ 100000
`define LDD_WDOG_CYC (`LDD_WDOG_MS * `LDD_CLK_KHZ)

`endif

// >>> hdl/ldd_pkg.sv
// Types shared by the LED frame and diagnostics block.
package ldd_pkg;

  // ========================================================================
  // Detection forcing state of the sinks
  // ========================================================================
  typedef enum logic [2:0] {
    LDD_DET_IDLE = 3'b001,
    LDD_DET_TEST = 3'b010,
    LDD_DET_DARK = 3'b100
  } ldd_det_e;

  // ========================================================================
  // Analog comparator results, per channel plus the single thermal and reference flags
  // ========================================================================
  typedef struct packed {
    logic [15:0] low;
    logic [15:0] high;
    logic therm;
    logic rext;
  } ldd_sense_s;

  // ========================================================================
  // State of the system-clock domain
  // ========================================================================
  typedef struct packed {
    logic stb_m;
    logic stb_s;
    logic stb_p;
    logic sin_m;
    logic sin_s;
    logic sin_p;
    logic gs_m;
    logic gs_s;
    logic gs_p;
    logic tg_m;
    logic tg_s;
    logic tg_p;
    ldd_sense_s sn_m;
    ldd_sense_s sn_s;
    logic [15:0] sr_m;
    logic [15:0] sr_s;
    logic [15:0] snap;
    logic [3:0] pcnt;
    logic [3:0] ecnt;
    logic [15:0] cmd;
    logic [15:0][15:0] tmp;
    logic [15:0][15:0] stg;
    logic [15:0][15:0] act;
    logic [3:0] idx;
    logic pend;
    logic [15:0] gcnt;
    logic [31:0] wd;
    logic wd_trip;
    logic sleep;
    ldd_det_e det;
    logic [15:0] res;
    logic res_tgl;
    logic [15:0] sink;
    logic test_i;
  } ldd_sys_s;

  // ========================================================================
  // State of the shift-clock domain
  // ========================================================================
  typedef struct packed {
    logic lr_m;
    logic lr_s;
    logic [15:0] sr;
    logic dout;
    logic tgl;
    logic ack;
  } ldd_lnk_s;

endpackage

// >>> hdl/ldd_top.sv
// Frame loading, waveform generation and diagnostics of a 16-channel LED sink driver.
`timescale 1ns/1ps
`default_nettype none
`include "ldd_regs.svh"

module ldd_top #(
  parameter int unsigned WDOG_CYCLES = `LDD_WDOG_CYC
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic shift_clock,
  input wire logic serial_in_pin,
  input wire logic latch_strobe,
  input wire logic grayscale_clock,
  input wire logic error_detect_mode,
  input wire ldd_pkg::ldd_sense_s sense,
  output logic serial_out,
  output logic [15:0] sink_on,
  output logic test_current,
  output logic sleep_mode,
  output logic [1:0] short_thresh_sel,
  output logic [5:0] gain_code,
  output logic watchdog_tripped
);

  ldd_pkg::ldd_sys_s s_q;
  ldd_pkg::ldd_sys_s s_d;
  ldd_pkg::ldd_lnk_s l_q;
  ldd_pkg::ldd_lnk_s l_d;
  logic [15:0] wave;
  logic [15:0] half;
  logic seg128;

  // ========================================================================
  // Waveform generator
  // ========================================================================
  // All channels at or above half scale select the finer segmentation.
  assign seg128 = &half;

  // The low counter bits pick the segment, so on-time spreads over the period.
  for (genvar ch = 0; ch < 16; ch++) begin : g_wave
    logic [15:0] rot;
    assign half[ch] = s_q.act[ch][15];
    assign rot = seg128 ? {s_q.gcnt[6:0], s_q.gcnt[15:7]} : {s_q.gcnt[5:0], s_q.gcnt[15:6]};
    assign wave[ch] = s_q.cmd[`LDD_CMD_PWM] ? (s_q.gcnt < s_q.act[ch]) : (rot < s_q.act[ch]);
  end

  // ========================================================================
  // System-clock domain
  // ========================================================================
  // Synchronises pins, counts pulses, decodes instructions and drives sinks.
  always_comb begin
    logic stb_rise;
    logic stb_fall;
    logic sin_rise;
    logic gs_edge;
    logic shift_seen;
    logic [15:0][15:0] nt;
    stb_rise = 1'b0;
    stb_fall = 1'b0;
    sin_rise = 1'b0;
    gs_edge = 1'b0;
    shift_seen = 1'b0;
    nt = s_q.tmp;
    s_d = s_q;
    // Two-flop synchronisers plus an edge-detect flop; the first stage is not read below.
    s_d.stb_m = latch_strobe;
    s_d.stb_s = s_q.stb_m;
    s_d.stb_p = s_q.stb_s;
    s_d.sin_m = serial_in_pin;
    s_d.sin_s = s_q.sin_m;
    s_d.sin_p = s_q.sin_s;
    s_d.gs_m = grayscale_clock;
    s_d.gs_s = s_q.gs_m;
    s_d.gs_p = s_q.gs_s;
    s_d.tg_m = l_q.tgl;
    s_d.tg_s = s_q.tg_m;
    s_d.tg_p = s_q.tg_s;
    s_d.sn_m = sense;
    s_d.sn_s = s_q.sn_m;
    s_d.sr_m = l_q.sr;
    s_d.sr_s = s_q.sr_m;
    stb_rise = s_q.stb_s & ~s_q.stb_p;
    stb_fall = ~s_q.stb_s & s_q.stb_p;
    sin_rise = s_q.sin_s & ~s_q.sin_p;
    gs_edge = s_q.gs_s ^ s_q.gs_p;
    shift_seen = s_q.tg_s ^ s_q.tg_p;

    // Pulse counters restart at each strobe and saturate.
    if (stb_rise) begin
      s_d.pcnt = 4'h0;
      s_d.ecnt = 4'h0;
      s_d.snap = s_q.sr_s;
    end else if (s_q.stb_s) begin
      if (sin_rise && s_q.pcnt != 4'hf) begin
        s_d.pcnt = s_q.pcnt + 4'h1;
      end
      if (shift_seen && s_q.ecnt != 4'hf) begin
        s_d.ecnt = s_q.ecnt + 4'h1;
      end
    end

    // Watchdog: counts cycles since the last grayscale edge.
    if (gs_edge) begin
      s_d.wd = 32'h0;
      s_d.wd_trip = 1'b0;
    end else begin
      if (s_q.wd < WDOG_CYCLES) begin
        s_d.wd = s_q.wd + 32'h1;
      end
      s_d.wd_trip = s_q.cmd[`LDD_CMD_WDOG] && (s_q.wd >= WDOG_CYCLES);
    end

    // Grayscale counter advances on both clock edges; wrap ends a frame.
    if (gs_edge) begin
      s_d.gcnt = s_q.gcnt + 16'h1;
      if (s_q.gcnt == `LDD_CNT_MAX && s_q.pend) begin
        s_d.act = s_q.stg;
        s_d.pend = 1'b0;
      end
    end

    // The detection window closes at the first shift edge after the strobe.
    if (shift_seen && !s_q.stb_s) begin
      s_d.det = ldd_pkg::LDD_DET_IDLE;
    end

    // Decode at the strobe fall; any strobe other than the sleep instruction ends sleep.
    if (stb_fall) begin
      s_d.sleep = 1'b0;
      if (error_detect_mode) begin
        case (s_q.pcnt)
          `LDD_E_OPEN: begin
            s_d.det = ldd_pkg::LDD_DET_TEST;
            s_d.res = ~s_q.sn_s.low;
            s_d.res_tgl = ~s_q.res_tgl;
          end
          `LDD_E_SHORT: begin
            s_d.det = ldd_pkg::LDD_DET_TEST;
            s_d.res = ~s_q.sn_s.high;
            s_d.res_tgl = ~s_q.res_tgl;
          end
          `LDD_E_S2G: begin
            s_d.det = ldd_pkg::LDD_DET_DARK;
            s_d.res = ~s_q.sn_s.low;
            s_d.res_tgl = ~s_q.res_tgl;
          end
          `LDD_E_SMART: begin
            s_d.det = ldd_pkg::LDD_DET_TEST;
            s_d.res = ~(s_q.sn_s.low | s_q.sn_s.high);
            s_d.res_tgl = ~s_q.res_tgl;
          end
          `LDD_E_THERM: begin
            s_d.res = {~s_q.sn_s.therm, 14'h3fff, ~s_q.wd_trip};
            s_d.res_tgl = ~s_q.res_tgl;
          end
          `LDD_E_REXT: begin
            s_d.res = {~s_q.sn_s.rext, 14'h3fff, ~s_q.wd_trip};
            s_d.res_tgl = ~s_q.res_tgl;
          end
          `LDD_E_SLEEP: begin
            s_d.sleep = 1'b1;
          end
          default: begin
          end
        endcase
      end else begin
        case (s_q.ecnt[3:1])
          `LDD_N_DATA: begin
            s_d.tmp[s_q.idx] = s_q.snap;
            if (s_q.idx != 4'h0) begin
              s_d.idx = s_q.idx - 4'h1;
            end
          end
          `LDD_N_GLOBAL: begin
            if (!s_q.cmd[`LDD_CMD_FMT]) begin
              nt[0] = s_q.snap;
            end
            s_d.tmp = nt;
            s_d.idx = `LDD_LAST_CH;
            if (s_q.cmd[`LDD_CMD_SYNC]) begin
              s_d.act = nt;
              s_d.pend = 1'b0;
            end else begin
              s_d.stg = nt;
              s_d.pend = 1'b1;
            end
          end
          `LDD_N_READ: begin
            s_d.res = s_q.cmd;
            s_d.res_tgl = ~s_q.res_tgl;
          end
          `LDD_N_WCMD: begin
            s_d.cmd = s_q.snap;
          end
          `LDD_N_CRST: begin
            if (s_q.cmd[`LDD_CMD_CRST]) begin
              s_d.gcnt = 16'h0;
            end
          end
          default: begin
          end
        endcase
      end
    end

    // Sink drive from the forcing state, then the global off conditions.
    unique case (s_q.det)
      ldd_pkg::LDD_DET_IDLE: begin
        s_d.sink = wave;
        s_d.test_i = 1'b0;
      end
      ldd_pkg::LDD_DET_TEST: begin
        s_d.sink = `LDD_ALL_ON;
        s_d.test_i = 1'b1;
      end
      ldd_pkg::LDD_DET_DARK: begin
        s_d.sink = 16'h0;
        s_d.test_i = 1'b0;
      end
    endcase
    if (s_q.sleep || s_q.wd_trip) begin
      s_d.sink = 16'h0;
    end

    // Synchronous reset.
    if (!rst_n) begin
      s_d = '0;
      s_d.cmd = `LDD_CMD_RST;
      s_d.idx = `LDD_LAST_CH;
      s_d.det = ldd_pkg::LDD_DET_IDLE;
    end
  end

  // Registers the system-domain state.
  always_ff @(posedge clock) begin
    s_q <= s_d;
  end

  // ========================================================================
  // Shift-clock domain
  // ========================================================================
  // Shifts data, retimes the chain and loads captured results.
  always_comb begin
    l_d = l_q;
    l_d.lr_m = rst_n;
    l_d.lr_s = l_q.lr_m;
    l_d.tgl = ~l_q.tgl;
    if (latch_strobe) begin
      l_d.dout = serial_in_pin;
    end else if (s_q.res_tgl != l_q.ack) begin
      l_d.ack = s_q.res_tgl;
      l_d.dout = s_q.res[15];
      l_d.sr = {s_q.res[14:0], serial_in_pin};
    end else begin
      l_d.dout = l_q.sr[15];
      l_d.sr = {l_q.sr[14:0], serial_in_pin};
    end
    if (!l_q.lr_s) begin
      l_d.sr = 16'h0;
      l_d.dout = 1'b0;
      l_d.tgl = 1'b0;
      l_d.ack = 1'b0;
    end
  end

  // Registers the shift-domain state.
  always_ff @(posedge shift_clock) begin
    l_q <= l_d;
  end

  // ========================================================================
  // Outputs
  // ========================================================================
  // All outputs come straight from flip-flops.
  assign serial_out = l_q.dout;
  assign sink_on = s_q.sink;
  assign test_current = s_q.test_i;
  assign sleep_mode = s_q.sleep;
  assign short_thresh_sel = s_q.cmd[`LDD_CMD_VTH_HI:`LDD_CMD_VTH_LO];
  assign gain_code = s_q.cmd[`LDD_CMD_GCC_HI:`LDD_CMD_GCC_LO];
  assign watchdog_tripped = s_q.wd_trip;

endmodule

`default_nettype wire

// >>> tb/ldd_top_sva.sv
// Concurrent checks on the ports of the LED frame block.
`timescale 1ns/1ps
`default_nettype none
module ldd_chk #(
  parameter int unsigned WDOG_CYCLES = 200
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic shift_clock,
  input wire logic serial_in_pin,
  input wire logic latch_strobe,
  input wire logic grayscale_clock,
  input wire logic error_detect_mode,
  input wire logic serial_out,
  input wire logic [15:0] sink_on,
  input wire logic test_current,
  input wire logic sleep_mode,
  input wire logic [1:0] short_thresh_sel,
  input wire logic [5:0] gain_code,
  input wire logic watchdog_tripped
);
  // ==========================================================================
  // Helper logic
  // ==========================================================================
  logic [31:0] idle_q;
  // Counts system cycles since the grayscale pin last moved.
  always_ff @(posedge clock) begin
    if (!rst_n || $changed(grayscale_clock)) begin
      idle_q <= 32'h0;
    end else begin
      idle_q <= idle_q + 32'h1;
    end
  end
  // ==========================================================================
  // Properties
  // ==========================================================================
  property p_wdog_span;
    @(posedge clock) disable iff (!rst_n)
      $rose(watchdog_tripped) |-> idle_q >= WDOG_CYCLES && idle_q <= WDOG_CYCLES + 8;
  endproperty
  a_wdog_span: assert property (p_wdog_span) else $error("watchdog trip span wrong");
  property p_wdog_dark;
    @(posedge clock) disable iff (!rst_n) watchdog_tripped [*3] |-> sink_on == 16'h0;
  endproperty
  a_wdog_dark: assert property (p_wdog_dark) else $error("sinks on after trip");
  property p_wdog_clear;
    @(posedge clock) disable iff (!rst_n)
      watchdog_tripped && $changed(grayscale_clock) |-> ##[1:6] !watchdog_tripped;
  endproperty
  a_wdog_clear: assert property (p_wdog_clear) else $error("trip not cleared");
  property p_test_all;
    @(posedge clock) disable iff (!rst_n) test_current [*2] |-> sink_on == 16'hffff;
  endproperty
  a_test_all: assert property (p_test_all) else $error("test current without all sinks");
  property p_test_cause;
    @(posedge clock) disable iff (!rst_n)
      $rose(test_current) |-> error_detect_mode && !latch_strobe;
  endproperty
  a_test_cause: assert property (p_test_cause) else $error("test current without cause");
  property p_test_end;
    @(posedge clock) disable iff (!rst_n) test_current |-> ##[1:600] !test_current;
  endproperty
  a_test_end: assert property (p_test_end) else $error("test current stuck");
  property p_cmd_write;
    @(posedge clock) disable iff (!rst_n)
      $changed(gain_code) || $changed(short_thresh_sel) |-> !error_detect_mode && !latch_strobe;
  endproperty
  a_cmd_write: assert property (p_cmd_write) else $error("command moved unasked");
  property p_sleep_in;
    @(posedge clock) disable iff (!rst_n) $rose(sleep_mode) |-> error_detect_mode && !latch_strobe;
  endproperty
  a_sleep_in: assert property (p_sleep_in) else $error("sleep without cause");
  property p_sleep_dark;
    @(posedge clock) disable iff (!rst_n) sleep_mode [*3] |-> sink_on == 16'h0;
  endproperty
  a_sleep_dark: assert property (p_sleep_dark) else $error("sinks on in sleep");
  property p_sleep_out;
    @(posedge clock) disable iff (!rst_n) sleep_mode && $fell(latch_strobe) |-> ##[1:8] !sleep_mode;
  endproperty
  a_sleep_out: assert property (p_sleep_out) else $error("no wake on strobe");
  property p_retime;
    @(posedge shift_clock) disable iff (!rst_n) latch_strobe |=> serial_out == $past(serial_in_pin);
  endproperty
  a_retime: assert property (p_retime) else $error("serial output not retimed");
  c_sleep: cover property (@(posedge clock) $rose(sleep_mode));
  c_trip: cover property (@(posedge clock) $rose(watchdog_tripped));
  c_test: cover property (@(posedge clock) $rose(test_current));
endmodule
bind ldd_top ldd_chk #(.WDOG_CYCLES(WDOG_CYCLES)) u_chk (
  .clock(clock), .rst_n(rst_n), .shift_clock(shift_clock), .serial_in_pin(serial_in_pin),
  .latch_strobe(latch_strobe), .grayscale_clock(grayscale_clock),
  .error_detect_mode(error_detect_mode), .serial_out(serial_out), .sink_on(sink_on),
  .test_current(test_current), .sleep_mode(sleep_mode), .short_thresh_sel(short_thresh_sel),
  .gain_code(gain_code), .watchdog_tripped(watchdog_tripped));
`default_nettype wire

// >>> tb/ldd_ctl_model.sv
// Display controller model driving the serial chain and grayscale clock.
`timescale 1ns/1ps
`default_nettype none
module ldd_ctl_model (
  output logic shift_clock,
  output logic serial_in_pin,
  output logic latch_strobe,
  output logic grayscale_clock,
  input wire logic serial_out
);
  logic gck_run;
  // Idle levels; the shift clock stands low outside frames.
  initial begin
    shift_clock = 1'b0;
    serial_in_pin = 1'b0;
    latch_strobe = 1'b0;
    grayscale_clock = 1'b0;
    gck_run = 1'b1;
  end
  // Free-running grayscale clock, so auto sync needs nothing more.
  always begin
    #25;
    if (gck_run) grayscale_clock = ~grayscale_clock;
  end
  // Parks the grayscale clock high, as sleep wants.
  task automatic park_gck();
    gck_run = 1'b0;
    grayscale_clock = 1'b1;
  endtask
  // Lets the grayscale clock run free again.
  task automatic run_gck();
    gck_run = 1'b1;
  endtask
  // Steps a parked grayscale clock by a counted number of edges, 30 ns apart.
  task automatic step_gck(input int n);
    for (int i = 0; i < n; i++) begin
      #30 grayscale_clock = ~grayscale_clock;
    end
  endtask
  // One 80 ns link clock period, offset in phase from the system clock.
  task automatic pulse();
    #43 shift_clock = 1'b1;
    #37 shift_clock = 1'b0;
  endtask
  // Shifts a word in, most significant bit first, then drives the line to the inverse of the last bit.
  task automatic send_word(input logic [15:0] w);
    for (int i = 15; i >= 0; i--) begin
      serial_in_pin = w[i];
      pulse();
    end
    serial_in_pin = ~w[0];
  endtask
  // Strobe carrying n pulses on the shift clock or the serial input.
  task automatic strobe(input int n, input bit on_din);
    serial_in_pin = 1'b0;
    latch_strobe = 1'b1;
    #60;
    for (int i = 0; i < n; i++) begin
      if (on_din) begin
        serial_in_pin = 1'b1;
        #40 serial_in_pin = 1'b0;
        #40;
      end else begin
        serial_in_pin = i[0];
        pulse();
      end
    end
    #60 latch_strobe = 1'b0;
    #200; // Detection window before the next shift edge.
  endtask
  // Clocks sixteen bits out of the serial output.
  task automatic read_word(output logic [15:0] w);
    for (int i = 15; i >= 0; i--) begin
      #43 shift_clock = 1'b1;
      #22 w[i] = serial_out;
      #15 shift_clock = 1'b0;
    end
  endtask
endmodule
`default_nettype wire

// >>> tb/tb.sv
// Self-checking bench for the LED frame and diagnostics block.
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clock, rst_n, error_detect_mode;
  ldd_pkg::ldd_sense_s sense;
  wire logic shift_clock, serial_in_pin, latch_strobe, grayscale_clock, serial_out;
  wire logic test_current, sleep_mode, watchdog_tripped;
  wire logic [15:0] sink_on;
  wire logic [1:0] short_thresh_sel;
  wire logic [5:0] gain_code;
  int n_errors = 0;
  int samples_checked = 0;
  logic [15:0] rd;
  ldd_top #(.WDOG_CYCLES(200)) u_dut (
    .clock(clock), .rst_n(rst_n), .shift_clock(shift_clock), .serial_in_pin(serial_in_pin),
    .latch_strobe(latch_strobe), .grayscale_clock(grayscale_clock),
    .error_detect_mode(error_detect_mode), .sense(sense), .serial_out(serial_out),
    .sink_on(sink_on), .test_current(test_current), .sleep_mode(sleep_mode),
    .short_thresh_sel(short_thresh_sel), .gain_code(gain_code),
    .watchdog_tripped(watchdog_tripped));
  ldd_ctl_model u_ctl (
    .shift_clock(shift_clock), .serial_in_pin(serial_in_pin), .latch_strobe(latch_strobe),
    .grayscale_clock(grayscale_clock), .serial_out(serial_out));
  // System clock at 100 MHz.
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  // Compares a word result.
  task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Compares a flag result.
  task automatic chk_flag(input logic got, input logic exp);
    chk_word({15'h0, got}, {15'h0, exp});
  endtask
  // Prints the verdict and ends the run.
  task automatic complete_run();
    if (n_errors == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // Runs one detection, checks the sinks, then shifts the result out.
  task automatic detect(input int n, input logic tst, input logic [15:0] snk,
                        input logic [15:0] exp);
    u_ctl.strobe(n, 1'b1);
    chk_flag(test_current, tst);
    chk_word(sink_on, snk);
    u_ctl.read_word(rd);
    chk_word(rd, exp);
  endtask
  // Cuts a hang short.
  initial begin
    repeat (30000) @(posedge clock);
    n_errors++;
    complete_run();
  end
  // Main sequence.
  initial begin
    rst_n = 1'b0;
    error_detect_mode = 1'b0;
    sense = 34'h0;
    fork
      repeat (16) @(negedge clock);
      repeat (3) u_ctl.pulse();
    join
    @(negedge clock);
    rst_n = 1'b1;
    chk_word({8'h0, gain_code, short_thresh_sel}, 16'h00ac);
    repeat (4) @(negedge clock);
    u_ctl.send_word(16'h155c);
    u_ctl.strobe(10, 1'b0);
    chk_word({8'h0, gain_code, short_thresh_sel}, 16'h0057);
    u_ctl.strobe(6, 1'b0);
    u_ctl.read_word(rd);
    chk_word(rd, 16'h155c);
    u_ctl.strobe(8, 1'b0);
    for (int k = 15; k >= 1; k--) begin
      u_ctl.send_word(k == 3 ? 16'h0000 : 16'hffff);
      u_ctl.strobe(0, 1'b0);
    end
    u_ctl.send_word(16'hffff);
    u_ctl.strobe(2, 1'b0);
    repeat (8) @(negedge clock);
    chk_word(sink_on, 16'hfff7);
    @(negedge clock);
    error_detect_mode = 1'b1;
    sense.low = 16'h00f0;
    sense.high = 16'h0300;
    sense.therm = 1'b1;
    detect(2, 1'b1, 16'hffff, 16'hff0f);
    detect(4, 1'b1, 16'hffff, 16'hfcff);
    detect(10, 1'b1, 16'hffff, 16'hfc0f);
    detect(6, 1'b0, 16'h0000, 16'hff0f);
    detect(8, 1'b0, 16'hfff7, 16'h7fff);
    u_ctl.park_gck();
    u_ctl.strobe(12, 1'b1);
    chk_flag(sleep_mode, 1'b1);
    u_ctl.strobe(0, 1'b1);
    chk_flag(sleep_mode, 1'b0);
    u_ctl.run_gck();
    @(negedge clock);
    error_detect_mode = 1'b0;
    u_ctl.send_word(16'h155d);
    u_ctl.strobe(10, 1'b0);
    u_ctl.park_gck();
    repeat (260) @(negedge clock);
    chk_flag(watchdog_tripped, 1'b1);
    chk_word(sink_on, 16'h0000);
    error_detect_mode = 1'b1;
    sense.rext = 1'b1;
    detect(8, 1'b0, 16'h0000, 16'h7ffe);
    detect(14, 1'b0, 16'h0000, 16'h7ffe);
    u_ctl.run_gck();
    repeat (10) @(negedge clock);
    chk_flag(watchdog_tripped, 1'b0);
    // Sixteen-latch format with auto sync, density waveform and counter reset.
    error_detect_mode = 1'b0;
    u_ctl.send_word(16'h8ab0);
    u_ctl.strobe(10, 1'b0);
    chk_word({8'h0, gain_code, short_thresh_sel}, 16'h00ac);
    u_ctl.park_gck();
    u_ctl.strobe(12, 1'b0);
    for (int k = 15; k >= 0; k--) begin
      u_ctl.send_word(k == 0 ? 16'h0000 : 16'h0040);
      u_ctl.strobe(0, 1'b0);
    end
    u_ctl.send_word(16'hffff);
    u_ctl.strobe(2, 1'b0);
    repeat (8) @(negedge clock);
    // The old frame still drives the sinks until the current frame ends.
    chk_word(sink_on, 16'hfff7);
    u_ctl.send_word(16'h8eb0);
    u_ctl.strobe(10, 1'b0);
    u_ctl.strobe(2, 1'b0);
    repeat (8) @(negedge clock);
    // Channel 0 stays dark: the global latch carried no channel data.
    chk_word(sink_on, 16'hfffe);
    u_ctl.step_gck(64);
    repeat (8) @(negedge clock);
    // Count 64 picks segment 0 again, at its second step, where a plain pulse is already over.
    chk_word(sink_on, 16'hfffe);
    complete_run();
  end
endmodule
`default_nettype wire
